// file: logic/poc_top.sv
/*
  Power mode control and low power oscillator calibration, single module.
  Assumes one 50 MHz clock; both 128 kHz oscillator outputs arrive as
  plain inputs and are synchronised here before their edges are counted.
*/
// Contract
// - Power bit 8 runs the precision oscillator; clearing it stops it.
// - Power bit 5 clear stops PLL and timers clocked from the PLL.
// - PLL and core power bits reset to one and wake-up sets them.
// - Power bit 4 clear stops SRAM, flash, GPIO, SPI; reset and wake set it.
// - LIN wake detection and low-power-clocked wake-up timer keep running.
// - Power bit 3 clear halts the core; software adds a dummy cycle.
// - Divider bits 2..0 give 20.48 MHz over two to the field; reset 001.
// - Low power trim is 8 bits, writable and LIN-updatable.
// - Precision trim is 10 bits, writable and LIN-updatable.
// - A read-only register shows the low power trim in use.
// - A read-only register shows precision trim, 11 bits, 10 used.
// - Reference counter 9 bits on precision edges, other 10 bits.
// - Both counters stop and hold when the reference reaches 0x1FF.
// - Low power trim writes need key 0x1324 written first each time.
// - One pass lasts about 4 ms on the precision oscillator.
// - Control bit 0 starts or aborts; bit 3 resets counters and disables.
// - Control bits 1 and 2 clear reference and low power counters.
// - Status gives busy, complete (cleared by reading the low power count) and finish flag (cleared by a status read).
// - PLL source bit zero picks low power, one picks precision.
`timescale 1ns/100ps
`default_nettype none

module poc_top
  import poc_pkg::*;
#(
  parameter int GUARD_CYCLES = CAL_GUARD_CYCLES
) (
  // Clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RESET,
  // Register port
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  // Oscillators and wake-up
  input  wire logic              PREC_OSC_CLK,
  input  wire logic              LP_OSC_CLK,
  input  wire logic              WAKE_EVENT,
  // Timer clock sources
  input  wire logic              GP_TIMER_FROM_PLL,
  input  wire logic              WAKE_TIMER_FROM_LP,
  // LIN derived trim updates
  input  wire logic              LIN_LP_TRIM_VALID,
  input  wire logic [7:0]        LIN_LP_TRIM,
  input  wire logic              LIN_PREC_TRIM_VALID,
  input  wire logic [9:0]        LIN_PREC_TRIM,
  // Power domain controls
  output logic                   PREC_OSC_EN,
  output logic                   PLL_PWR,
  output logic                   PERIPH_PWR,
  output logic                   CORE_HALT,
  output logic      [2:0]        CORE_CLOCK_DIVIDER,
  output logic                   GP_TIMER_RUN,
  output logic                   WAKE_TIMER_RUN,
  output logic                   LIN_WAKE_DETECT_EN,
  output logic                   PLL_SRC_PREC,
  // Trims in use
  output logic      [7:0]        LP_TRIM,
  output logic      [9:0]        PREC_TRIM
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0]       r);
    return a == r;
  endfunction

  logic wr_power;
  logic wr_pll_src;
  logic wr_cal_ctrl;
  logic wr_lp_user;
  logic wr_prec_user;
  logic wr_key;
  logic rd_status;
  logic rd_lp_cnt;

  assign wr_power     = WR && hit(ADDR, ADDR_POWER_CTRL);
  assign wr_pll_src   = WR && hit(ADDR, ADDR_PLL_SRC);
  assign wr_cal_ctrl  = WR && hit(ADDR, ADDR_CAL_CTRL);
  assign wr_lp_user   = WR && hit(ADDR, ADDR_LP_USER);
  assign wr_prec_user = WR && hit(ADDR, ADDR_PREC_USER);
  assign wr_key       = WR && hit(ADDR, ADDR_TRIM_KEY);
  assign rd_status    = RD && hit(ADDR, ADDR_CAL_STATUS);
  assign rd_lp_cnt    = RD && hit(ADDR, ADDR_LP_CNT);

  // ----------------------------------------------------------------------
  // Power mode control
  // ----------------------------------------------------------------------
  poc_power_t power_q;

  // Software is trusted to clear the core, peripheral and PLL bits in
  // the documented combinations; no ordering is enforced here.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      power_q <= poc_power_t'(PWR_RESET);
    end else begin
      if (wr_power) begin
        power_q <= poc_power_t'(WDATA[PWR_W-1:0]);
      end
      if (WAKE_EVENT) begin
        // Wake-up wins over a same-cycle power-down write
        power_q.pll_pwr    <= 1'b1;
        power_q.periph_pwr <= 1'b1;
        power_q.core_pwr   <= 1'b1;
      end
    end
  end

  assign PREC_OSC_EN        = power_q.prec_osc_en;
  assign PLL_PWR            = power_q.pll_pwr;
  assign PERIPH_PWR         = power_q.periph_pwr;
  assign CORE_HALT          = !power_q.core_pwr;
  assign CORE_CLOCK_DIVIDER = power_q.core_clock_divider;
  assign GP_TIMER_RUN       = !GP_TIMER_FROM_PLL || power_q.pll_pwr;
  assign WAKE_TIMER_RUN     = WAKE_TIMER_FROM_LP || power_q.pll_pwr;
  assign LIN_WAKE_DETECT_EN = 1'b1;

  // ----------------------------------------------------------------------
  // PLL source select
  // ----------------------------------------------------------------------
  logic pll_src_q;

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      pll_src_q <= 1'b0;
    end else if (wr_pll_src) begin
      pll_src_q <= WDATA[0];
    end
  end

  assign PLL_SRC_PREC = pll_src_q;

  // ----------------------------------------------------------------------
  // Trim registers and key
  // ----------------------------------------------------------------------
  logic                   key_armed_q;
  logic [LP_TRIM_W-1:0]   lp_user_q;
  logic [PREC_TRIM_W-1:0] prec_user_q;
  logic [LP_TRIM_W-1:0]   lp_active_q;
  logic [PREC_TRIM_W-1:0] prec_active_q;

  // Any low power trim write consumes the key, good or bad; a wrong key disarms.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      key_armed_q <= 1'b0;
    end else if (wr_key) begin
      key_armed_q <= (WDATA == TRIM_KEY);
    end else if (wr_lp_user) begin
      key_armed_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      lp_user_q <= LP_TRIM_RESET;
    end else if (wr_lp_user && key_armed_q) begin
      lp_user_q <= WDATA[LP_TRIM_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      prec_user_q <= PREC_TRIM_RESET;
    end else if (wr_prec_user) begin
      prec_user_q <= WDATA[PREC_TRIM_W-1:0];
    end
  end

  // The trim in use follows a user write, else the latest LIN update.
  // LIN never touches the user copies, so software must copy back.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      lp_active_q <= LP_TRIM_RESET;
    end else if (wr_lp_user && key_armed_q) begin
      lp_active_q <= WDATA[LP_TRIM_W-1:0];
    end else if (LIN_LP_TRIM_VALID) begin
      lp_active_q <= LIN_LP_TRIM;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      prec_active_q <= PREC_TRIM_RESET;
    end else if (wr_prec_user) begin
      prec_active_q <= WDATA[PREC_TRIM_W-1:0];
    end else if (LIN_PREC_TRIM_VALID) begin
      prec_active_q <= LIN_PREC_TRIM;
    end
  end

  // Higher code slows the oscillator; the analog trim takes it as is
  assign LP_TRIM   = lp_active_q;
  assign PREC_TRIM = prec_active_q;

  // ----------------------------------------------------------------------
  // Oscillator synchronisers and edge detect
  // ----------------------------------------------------------------------
  logic [1:0] prec_sync_q;
  logic [1:0] lp_sync_q;
  logic       prec_last_q;
  logic       lp_last_q;
  logic       prec_edge;
  logic       lp_edge;

  // Second stage feeds the edge detect; the first is never read else.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      prec_sync_q <= 2'h0;
      lp_sync_q   <= 2'h0;
      prec_last_q <= 1'b0;
      lp_last_q   <= 1'b0;
    end else begin
      prec_sync_q <= {prec_sync_q[0], PREC_OSC_CLK};
      lp_sync_q   <= {lp_sync_q[0], LP_OSC_CLK};
      prec_last_q <= prec_sync_q[1];
      lp_last_q   <= lp_sync_q[1];
    end
  end

  assign prec_edge = prec_sync_q[1] && !prec_last_q;
  assign lp_edge   = lp_sync_q[1] && !lp_last_q;

  // ----------------------------------------------------------------------
  // Calibration control
  // ----------------------------------------------------------------------
  logic [CAL_CTRL_W-1:0] cal_ctrl_q;
  logic                  cal_en_last_q;
  logic                  cal_start;
  logic                  cal_rst;

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cal_ctrl_q <= 4'h0;
    end else if (wr_cal_ctrl) begin
      cal_ctrl_q <= WDATA[CAL_CTRL_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cal_en_last_q <= 1'b0;
    end else begin
      cal_en_last_q <= cal_ctrl_q[BIT_CAL_EN];
    end
  end

  assign cal_rst   = cal_ctrl_q[BIT_CAL_RST];
  assign cal_start = cal_ctrl_q[BIT_CAL_EN] && !cal_en_last_q && !cal_rst;

  // ----------------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    POC_IDLE,
    POC_RUN,
    POC_HOLD
  } poc_state_t;

  poc_state_t  state_q;
  logic        ref_full;
  logic        guard_hit;
  logic [31:0] guard_q;

  logic [REF_W-1:0] ref_cnt_q;
  logic [LP_W-1:0]  lp_cnt_q;

  assign ref_full  = (state_q == POC_RUN) && (ref_cnt_q == REF_MAX);
  assign guard_hit = (state_q == POC_RUN) &&
                     (guard_q == 32'(GUARD_CYCLES - 1));

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= POC_IDLE;
    end else begin
      unique case (state_q)
        POC_IDLE: begin
          if (cal_start) begin
            state_q <= POC_RUN;
          end
        end
        POC_RUN: begin
          if (cal_rst || !cal_ctrl_q[BIT_CAL_EN]) begin
            state_q <= POC_IDLE;
          end else if (ref_full || guard_hit) begin
            state_q <= POC_HOLD;
          end
        end
        POC_HOLD: begin
          if (cal_rst || !cal_ctrl_q[BIT_CAL_EN]) begin
            state_q <= POC_IDLE;
          end
        end
      endcase
    end
  end

  // A dead precision oscillator would leave the pass busy forever, so
  // a guard of twice the nominal pass ends it without the done flag.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      guard_q <= 32'h0;
    end else if (state_q != POC_RUN) begin
      guard_q <= 32'h0;
    end else begin
      guard_q <= guard_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Calibration counters
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ref_cnt_q <= 9'h000;
    end else if (cal_rst || cal_start || cal_ctrl_q[BIT_REF_CLR]) begin
      ref_cnt_q <= 9'h000;
    end else if (state_q == POC_RUN && prec_edge && !ref_full) begin
      ref_cnt_q <= ref_cnt_q + 9'h001;
    end
  end

  // The low power count stops in the same cycle the reference fills.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      lp_cnt_q <= 10'h000;
    end else if (cal_rst || cal_start || cal_ctrl_q[BIT_LP_CLR]) begin
      lp_cnt_q <= 10'h000;
    end else if (state_q == POC_RUN && lp_edge && !ref_full) begin
      lp_cnt_q <= lp_cnt_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Calibration status
  // ----------------------------------------------------------------------
  poc_cal_status_t status;
  logic            done_q;
  logic            irq_q;
  logic            busy_fall;

  assign busy_fall = (state_q == POC_RUN) &&
                     (cal_rst || !cal_ctrl_q[BIT_CAL_EN] || ref_full ||
                      guard_hit);

  // Set wins over a read in the same cycle for both sticky flags.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      done_q <= 1'b0;
    end else if (ref_full && !cal_rst && cal_ctrl_q[BIT_CAL_EN]) begin
      done_q <= 1'b1;
    end else if (rd_lp_cnt) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      irq_q <= 1'b0;
    end else if (busy_fall) begin
      irq_q <= 1'b1;
    end else if (rd_status) begin
      irq_q <= 1'b0;
    end
  end

  assign status.done = done_q;
  assign status.busy = (state_q == POC_RUN);
  assign status.irq  = irq_q;

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    unique case (1'b1)
      hit(ADDR, ADDR_POWER_CTRL):  rd_mux = 16'(power_q);
      hit(ADDR, ADDR_PLL_SRC):     rd_mux = 16'(pll_src_q);
      hit(ADDR, ADDR_CAL_CTRL):    rd_mux = 16'(cal_ctrl_q);
      hit(ADDR, ADDR_CAL_STATUS):  rd_mux = 16'(status);
      hit(ADDR, ADDR_REF_CNT):     rd_mux = 16'(ref_cnt_q);
      hit(ADDR, ADDR_LP_CNT):      rd_mux = 16'(lp_cnt_q);
      hit(ADDR, ADDR_LP_USER):     rd_mux = 16'(lp_user_q);
      hit(ADDR, ADDR_PREC_USER):   rd_mux = 16'(prec_user_q);
      hit(ADDR, ADDR_LP_ACTIVE):   rd_mux = 16'(lp_active_q);
      hit(ADDR, ADDR_PREC_ACTIVE): begin
        rd_mux = 16'(prec_active_q);
      end
      default:                     rd_mux = 16'h0000;
    endcase
  end

  // Key register is write-only and reads zero
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      RDATA <= rd_mux;
    end else begin
      RDATA <= 16'h0000;
    end
  end

endmodule // poc_top

`default_nettype wire

// file: logic/poc_pkg.sv
/*
  Shared constants and carriers for the power mode and oscillator
  calibration block. Assumes a 16-bit register port with 12-bit byte
  addresses and a 50 MHz system clock.
*/
package poc_pkg;

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;

  localparam logic [11:0] ADDR_POWER_CTRL  = 12'h408;
  localparam logic [11:0] ADDR_PLL_SRC     = 12'h414;
  localparam logic [11:0] ADDR_CAL_CTRL    = 12'h440;
  localparam logic [11:0] ADDR_CAL_STATUS  = 12'h444;
  localparam logic [11:0] ADDR_REF_CNT     = 12'h448;
  localparam logic [11:0] ADDR_LP_CNT      = 12'h44C;
  localparam logic [11:0] ADDR_LP_USER     = 12'h4A0;
  localparam logic [11:0] ADDR_PREC_USER   = 12'h4A4;
  localparam logic [11:0] ADDR_LP_ACTIVE   = 12'h4A8;
  localparam logic [11:0] ADDR_PREC_ACTIVE = 12'h4AC;
  localparam logic [11:0] ADDR_TRIM_KEY    = 12'h4B0;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int PWR_W           = 12;
  localparam int BIT_PREC_OSC_EN = 8;
  localparam int BIT_PLL_PWR     = 5;
  localparam int BIT_PERIPH_PWR  = 4;
  localparam int BIT_CORE_PWR    = 3;
  localparam int DIV_LSB         = 0;
  localparam int DIV_W           = 3;
  localparam logic [11:0] PWR_RESET = 12'h079;

  localparam int BIT_CAL_EN      = 0;
  localparam int BIT_REF_CLR     = 1;
  localparam int BIT_LP_CLR      = 2;
  localparam int BIT_CAL_RST     = 3;
  localparam int CAL_CTRL_W      = 4;

  localparam int BIT_ST_IRQ      = 0;
  localparam int BIT_ST_BUSY     = 1;
  localparam int BIT_ST_DONE     = 2;

  localparam int REF_W           = 9;
  localparam int LP_W            = 10;
  localparam logic [8:0] REF_MAX = 9'h1FF;

  localparam int LP_TRIM_W       = 8;
  localparam int PREC_TRIM_W     = 10;
  localparam int PREC_ACTIVE_W   = 11;
  localparam logic [7:0] LP_TRIM_RESET   = 8'h80;
  localparam logic [9:0] PREC_TRIM_RESET = 10'h200;
  localparam logic [15:0] TRIM_KEY       = 16'h1324;

  // ----------------------------------------------------------------------
  // Timing: one nominal pass, and a guard of twice that
  // ----------------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;
  localparam int CAL_PASS_US = 4000;
  localparam int CAL_PASS_CYCLES = (CAL_PASS_US / 1000) * (CLK_HZ / 1000);
  localparam int CAL_GUARD_CYCLES = 2 * CAL_PASS_CYCLES;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] reserved_hi;
    logic       prec_osc_en;
    logic [1:0] reserved_mid;
    logic       pll_pwr;
    logic       periph_pwr;
    logic       core_pwr;
    logic [2:0] core_clock_divider;
  } poc_power_t;

  typedef struct packed {
    logic done;
    logic busy;
    logic irq;
  } poc_cal_status_t;

endpackage

// file: testbench/poc_monitor.sv
/*
  Port checker for the power mode and calibration block.
  Assumes one clock and that the bench keeps every strobe low in reset.
*/
`timescale 1ns/100ps
`default_nettype none

module poc_monitor
  import poc_pkg::*;
(
  // Clock and register port
  input wire logic              REF_CLK,
  input wire logic              RESET,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR,
  input wire logic              RD,
  input wire logic [DATA_W-1:0] RDATA,
  // Events and sources
  input wire logic              WAKE_EVENT,
  input wire logic              GP_TIMER_FROM_PLL,
  input wire logic              WAKE_TIMER_FROM_LP,
  input wire logic              LIN_LP_TRIM_VALID,
  input wire logic [7:0]        LIN_LP_TRIM,
  // Controls and trims
  input wire logic              PREC_OSC_EN,
  input wire logic              PLL_PWR,
  input wire logic              PERIPH_PWR,
  input wire logic              CORE_HALT,
  input wire logic [2:0]        CORE_CLOCK_DIVIDER,
  input wire logic              GP_TIMER_RUN,
  input wire logic              WAKE_TIMER_RUN,
  input wire logic              LIN_WAKE_DETECT_EN,
  input wire logic              PLL_SRC_PREC,
  input wire logic [7:0]        LP_TRIM,
  input wire logic [9:0]        PREC_TRIM
);

  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  // Wake-up overrides bits 5..3, so those checks skip wake cycles
  logic pw;
  logic pwn;
  assign pw  = WR && (ADDR == ADDR_POWER_CTRL);
  assign pwn = pw && !WAKE_EVENT;

  property p_prec_en;
    pw |=> PREC_OSC_EN == $past(WDATA[BIT_PREC_OSC_EN]);
  endproperty
  a_prec_en: assert property (p_prec_en)
    else $error("precision osc enable wrong");
  property p_pll_pwr;
    pwn |=> PLL_PWR == $past(WDATA[BIT_PLL_PWR]);
  endproperty
  a_pll_pwr: assert property (p_pll_pwr)
    else $error("pll power wrong");
  property p_periph;
    pwn |=> PERIPH_PWR == $past(WDATA[BIT_PERIPH_PWR]);
  endproperty
  a_periph: assert property (p_periph)
    else $error("peripheral power wrong");
  property p_core;
    pwn |=> CORE_HALT != $past(WDATA[BIT_CORE_PWR]);
  endproperty
  a_core: assert property (p_core)
    else $error("core halt wrong");
  property p_wake;
    WAKE_EVENT |=> PLL_PWR && PERIPH_PWR && !CORE_HALT;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake left domain off");
  property p_div;
    pw |=> CORE_CLOCK_DIVIDER == $past(WDATA[2:0]);
  endproperty
  a_div: assert property (p_div)
    else $error("core divider wrong");
  property p_gp_timer;
    GP_TIMER_RUN == (!GP_TIMER_FROM_PLL || PLL_PWR);
  endproperty
  a_gp_timer: assert property (p_gp_timer)
    else $error("timer run wrong");
  property p_wake_timer;
    WAKE_TIMER_FROM_LP |-> WAKE_TIMER_RUN && LIN_WAKE_DETECT_EN;
  endproperty
  a_wake_timer: assert property (p_wake_timer)
    else $error("wake timer stopped");
  property p_pll_src;
    WR && ADDR == ADDR_PLL_SRC |=> PLL_SRC_PREC == $past(WDATA[0]);
  endproperty
  a_pll_src: assert property (p_pll_src)
    else $error("pll source wrong");
  property p_lin_lp;
    LIN_LP_TRIM_VALID && !(WR && ADDR == ADDR_LP_USER)
      |=> LP_TRIM == $past(LIN_LP_TRIM);
  endproperty
  a_lin_lp: assert property (p_lin_lp)
    else $error("lin trim not loaded");
  property p_lp_active_rd;
    RD && ADDR == ADDR_LP_ACTIVE |=> RDATA == {8'h00, $past(LP_TRIM)};
  endproperty
  a_lp_active_rd: assert property (p_lp_active_rd)
    else $error("active trim read wrong");

endmodule // poc_monitor

bind poc_top poc_monitor i_poc_monitor (
  .REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .WAKE_EVENT(WAKE_EVENT),
  .GP_TIMER_FROM_PLL(GP_TIMER_FROM_PLL),
  .WAKE_TIMER_FROM_LP(WAKE_TIMER_FROM_LP),
  .LIN_LP_TRIM_VALID(LIN_LP_TRIM_VALID), .LIN_LP_TRIM(LIN_LP_TRIM),
  .PREC_OSC_EN(PREC_OSC_EN), .PLL_PWR(PLL_PWR), .PERIPH_PWR(PERIPH_PWR),
  .CORE_HALT(CORE_HALT), .CORE_CLOCK_DIVIDER(CORE_CLOCK_DIVIDER),
  .GP_TIMER_RUN(GP_TIMER_RUN), .WAKE_TIMER_RUN(WAKE_TIMER_RUN),
  .LIN_WAKE_DETECT_EN(LIN_WAKE_DETECT_EN), .PLL_SRC_PREC(PLL_SRC_PREC),
  .LP_TRIM(LP_TRIM), .PREC_TRIM(PREC_TRIM));

`default_nettype wire

// file: testbench/poc_top_tb.sv
/*
  Self-checking bench for poc_top: register table rows, then power,
  key, trim and calibration cases. Both oscillators share one fast
  waveform so the two counts must match.
*/
`timescale 1ns/100ps
`default_nettype none

module poc_top_tb
  import poc_pkg::*;
;
  // ----------------
  // Signals
  // ----------------
  logic REF_CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0;
  logic [11:0] ADDR = 12'h000;
  logic [15:0] WDATA = 16'h0000, RDATA;
  logic PREC_OSC_CLK = 1'b0, LP_OSC_CLK = 1'b0, WAKE_EVENT = 1'b0;
  logic GP_TIMER_FROM_PLL = 1'b0, WAKE_TIMER_FROM_LP = 1'b1;
  logic LIN_LP_TRIM_VALID = 1'b0, LIN_PREC_TRIM_VALID = 1'b0;
  logic [7:0] LIN_LP_TRIM = 8'h00, LP_TRIM;
  logic [9:0] LIN_PREC_TRIM = 10'h000, PREC_TRIM;
  logic PREC_OSC_EN, PLL_PWR, PERIPH_PWR, CORE_HALT, GP_TIMER_RUN;
  logic WAKE_TIMER_RUN, LIN_WAKE_DETECT_EN, PLL_SRC_PREC;
  logic [2:0] CORE_CLOCK_DIVIDER;
  logic [15:0] st;
  int errors = 0, compares = 0, oc = 0;

  typedef struct packed {
    logic [11:0] wa;
    logic [15:0] wd;
    logic [11:0] ra;
    logic [15:0] ex;
  } poc_row_t;
  poc_row_t rows [6] = '{
    '{ADDR_POWER_CTRL, 16'h0107, ADDR_POWER_CTRL, 16'h0107},
    '{ADDR_PLL_SRC, 16'h0001, ADDR_PLL_SRC, 16'h0001},
    '{ADDR_PREC_USER, 16'h03FF, ADDR_PREC_ACTIVE, 16'h03FF},
    '{ADDR_LP_ACTIVE, 16'h0012, ADDR_LP_ACTIVE, 16'h0080},
    '{12'h7FC, 16'hFFFF, 12'h7FC, 16'h0000},
    '{ADDR_POWER_CTRL, 16'h0000, ADDR_POWER_CTRL, 16'h0000}};

  poc_top #(.GUARD_CYCLES(20000)) i_poc_top (
    .REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .PREC_OSC_CLK(PREC_OSC_CLK),
    .LP_OSC_CLK(LP_OSC_CLK), .WAKE_EVENT(WAKE_EVENT),
    .GP_TIMER_FROM_PLL(GP_TIMER_FROM_PLL),
    .WAKE_TIMER_FROM_LP(WAKE_TIMER_FROM_LP),
    .LIN_LP_TRIM_VALID(LIN_LP_TRIM_VALID), .LIN_LP_TRIM(LIN_LP_TRIM),
    .LIN_PREC_TRIM_VALID(LIN_PREC_TRIM_VALID), .LIN_PREC_TRIM(LIN_PREC_TRIM),
    .PREC_OSC_EN(PREC_OSC_EN), .PLL_PWR(PLL_PWR), .PERIPH_PWR(PERIPH_PWR),
    .CORE_HALT(CORE_HALT), .CORE_CLOCK_DIVIDER(CORE_CLOCK_DIVIDER),
    .GP_TIMER_RUN(GP_TIMER_RUN), .WAKE_TIMER_RUN(WAKE_TIMER_RUN),
    .LIN_WAKE_DETECT_EN(LIN_WAKE_DETECT_EN), .PLL_SRC_PREC(PLL_SRC_PREC),
    .LP_TRIM(LP_TRIM), .PREC_TRIM(PREC_TRIM));

  // ----------------
  // Clocks; oscillators far faster than nominal to keep runs short
  // ----------------
  initial begin
    forever #10 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    oc <= (oc == 4) ? 0 : oc + 1;
    if (oc == 4) begin
      PREC_OSC_CLK <= ~PREC_OSC_CLK;
      LP_OSC_CLK   <= ~LP_OSC_CLK;
    end
  end

  // ----------------
  // Tasks
  // ----------------
  task automatic end_sim;
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // A gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge REF_CLK); WR <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] q);
    ADDR <= a; RD <= 1'b1;
    @(posedge REF_CLK); RD <= 1'b0;
    #1 q = RDATA;
    @(posedge REF_CLK);
  endtask
  task automatic rc(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] q;
    rd(a, q);
    chk(q, exp);
  endtask

  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (3) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    rc(ADDR_POWER_CTRL, {4'h0, PWR_RESET});
    chk({6'h00, PREC_TRIM}, {6'h00, PREC_TRIM_RESET});
    rc(ADDR_CAL_STATUS, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rc(rows[i].ra, rows[i].ex);
    end
    chk({12'h000, PLL_PWR, PERIPH_PWR, CORE_HALT, GP_TIMER_RUN},
        16'h0003);
    chk({14'h0000, WAKE_TIMER_RUN, LIN_WAKE_DETECT_EN}, 16'h0003);
    GP_TIMER_FROM_PLL <= 1'b1; WAKE_TIMER_FROM_LP <= 1'b0;
    @(posedge REF_CLK);
    chk({14'h0000, GP_TIMER_RUN, WAKE_TIMER_RUN}, 16'h0000);
    WAKE_EVENT <= 1'b1;
    @(posedge REF_CLK); WAKE_EVENT <= 1'b0;
    @(posedge REF_CLK);
    rc(ADDR_POWER_CTRL, 16'h0038);
    chk({15'h0000, GP_TIMER_RUN}, 16'h0001);
    for (int d = 0; d < 8; d++) begin
      wr(ADDR_POWER_CTRL, 16'h0138 | d[15:0]);
      chk({12'h000, PREC_OSC_EN, CORE_CLOCK_DIVIDER},
          {12'h000, 1'b1, d[2:0]});
    end
    // Trim key: one write per arming, wrong key disarms
    wr(ADDR_LP_USER, 16'h0055);
    chk({8'h00, LP_TRIM}, 16'h0080);
    wr(ADDR_TRIM_KEY, TRIM_KEY);
    wr(ADDR_LP_USER, 16'h0055);
    rc(ADDR_LP_USER, 16'h0055);
    wr(ADDR_LP_USER, 16'h0066);
    chk({8'h00, LP_TRIM}, 16'h0055);
    wr(ADDR_TRIM_KEY, TRIM_KEY);
    wr(ADDR_TRIM_KEY, 16'h1325);
    wr(ADDR_LP_USER, 16'h0077);
    chk({8'h00, LP_TRIM}, 16'h0055);
    LIN_LP_TRIM <= 8'h3C; LIN_LP_TRIM_VALID <= 1'b1;
    LIN_PREC_TRIM <= 10'h155; LIN_PREC_TRIM_VALID <= 1'b1;
    @(posedge REF_CLK);
    LIN_LP_TRIM_VALID <= 1'b0; LIN_PREC_TRIM_VALID <= 1'b0;
    @(posedge REF_CLK);
    chk({8'h00, LP_TRIM}, 16'h003C);
    chk({6'h00, PREC_TRIM}, 16'h0155);
    rc(ADDR_LP_ACTIVE, 16'h003C);
    // Full pass, then hold, then aborts and counter clears
    wr(ADDR_CAL_CTRL, 16'h0001);
    rc(ADDR_CAL_STATUS, 16'h0002);
    st = 16'h0000;
    for (int n = 0; n < 4000 && st[BIT_ST_DONE] !== 1'b1; n++) begin
      rd(ADDR_CAL_STATUS, st);
    end
    chk(st, 16'h0005);
    rc(ADDR_CAL_STATUS, 16'h0004);
    rc(ADDR_REF_CNT, 16'h01FF);
    rc(ADDR_LP_CNT, 16'h01FF);
    rc(ADDR_CAL_STATUS, 16'h0000);
    repeat (40) @(posedge REF_CLK);
    rc(ADDR_REF_CNT, 16'h01FF);
    wr(ADDR_CAL_CTRL, 16'h0000);
    wr(ADDR_CAL_CTRL, 16'h0001);
    repeat (100) @(posedge REF_CLK);
    wr(ADDR_CAL_CTRL, 16'h0000);
    rc(ADDR_CAL_STATUS, 16'h0001);
    wr(ADDR_CAL_CTRL, 16'h0002);
    rc(ADDR_REF_CNT, 16'h0000);
    wr(ADDR_CAL_CTRL, 16'h0004);
    rc(ADDR_LP_CNT, 16'h0000);
    wr(ADDR_CAL_CTRL, 16'h0001);
    repeat (100) @(posedge REF_CLK);
    wr(ADDR_CAL_CTRL, 16'h0009);
    rc(ADDR_CAL_STATUS, 16'h0001);
    rc(ADDR_REF_CNT, 16'h0000);
    rc(ADDR_LP_CNT, 16'h0000);
    end_sim;
  end

endmodule // poc_top_tb

`default_nettype wire
